/* rtl/sld_consts.svh */
// Constants for the signed load decoder: encodings, field positions, widths
`ifndef SLD_CONSTS_SVH
`define SLD_CONSTS_SVH

// Narrow register-offset form
`define SLD_NARROW_OP_HI 15
`define SLD_NARROW_OP_LO 9
`define SLD_NARROW_OP 7'h2B
`define SLD_NARROW_OFF_HI 8
`define SLD_NARROW_OFF_LO 6
`define SLD_NARROW_BASE_HI 5
`define SLD_NARROW_BASE_LO 3
`define SLD_NARROW_DEST_HI 2
`define SLD_NARROW_DEST_LO 0

// Wide forms: upper halfword fields
`define SLD_WIDE_OP_HI 31
`define SLD_WIDE_OP_LO 24
`define SLD_WIDE_OP 8'hF9
`define SLD_WIDE_UBIT 23
`define SLD_WIDE_ZERO 22
`define SLD_WIDE_HALF 21
`define SLD_WIDE_LOAD 20
`define SLD_WIDE_BASE_HI 19
`define SLD_WIDE_BASE_LO 16

// Wide forms: lower halfword fields
`define SLD_WIDE_DEST_HI 15
`define SLD_WIDE_DEST_LO 12
`define SLD_WIDE_WOFF_HI 11
`define SLD_WIDE_NARROW_SEL 11
`define SLD_WIDE_PBIT 10
`define SLD_WIDE_UBIT8 9
`define SLD_WIDE_WBIT 8
`define SLD_WIDE_NOFF_HI 7
`define SLD_WIDE_REGZ_HI 11
`define SLD_WIDE_REGZ_LO 6
`define SLD_WIDE_SHIFT_HI 5
`define SLD_WIDE_SHIFT_LO 4
`define SLD_WIDE_OFF_HI 3
`define SLD_WIDE_OFF_LO 0

// Special register numbers, PC alignment mask and no-shift code
`define SLD_REG_PC 4'hF
`define SLD_REG_SP 4'hD
`define SLD_PC_ALIGN_MASK 32'hFFFFFFFC
`define SLD_SHIFT_NONE 2'h0

`endif

/* rtl/sld_pkg.sv */
// Types shared by the signed load decoder
`default_nettype none
package sld_pkg;

   typedef enum logic [3:0] {
      SLD_IDLE = 4'h1,
      SLD_ADDR = 4'h2,
      SLD_MEM  = 4'h4,
      SLD_WAIT = 4'h8
   } sld_state_e;

   typedef enum logic [4:0] {
      SLD_K_LOAD    = 5'h01,
      SLD_K_PRELOAD = 5'h02,
      SLD_K_HINT    = 5'h04,
      SLD_K_UNDEF   = 5'h08,
      SLD_K_OTHER   = 5'h10
   } sld_kind_e;

   typedef struct packed {
      sld_kind_e kind;
      logic half;
      logic pc_rel;
      logic reg_form;
      logic index;
      logic add;
      logic wback;
      logic unpriv;
      logic unpred;
      logic [3:0] dest;
      logic [3:0] base;
      logic [3:0] offr;
      logic [1:0] shift;
      logic [11:0] imm;
   } sld_dec_s;

endpackage
`default_nettype wire

/* rtl/sld_signed_load.sv */
// Signed byte/halfword load decode, address generation and writeback
// Overview of operation
// - Literal byte: aligned PC plus/minus offset, sign-extend
// - Literal byte: dest 15 preloads, dest 13 unpredictable
// - Register offset: base plus shifted offset, no writeback
// - Narrow register form decoded with zero shift
// - Wide register form: shift field, redirects, unpredictables
// - User byte load: base plus offset, unprivileged access
// - User load: dest 13/15 unpredictable, base 15 literal
// - Narrow immediate: P and W zero is undefined
// - Narrow immediate: P U W 110 is user form
// - P index, U add, W writeback; hazards unpredictable
// - Dest 15 with post, add or writeback unpredictable
// - Halfword immediate: sign-extend, optional base writeback
// - Offsets 0-4095 wide form, 0-255 narrow form
// - Subtract zero kept distinct from add zero
// - Literal halfword load from PC plus offset
// - Halfword: dest 15 is hint, base 15 literal
// - Memory hints act as no-operation
`timescale 1ns/1ps
`default_nettype none
`include "sld_consts.svh"

module sld_signed_load
   import sld_pkg::*;
(
   input wire logic i_clk,                 // Core clock
   input wire logic i_rst_b,               // Async reset, active low
   input wire logic i_instr_valid,         // Instruction offered
   input wire logic [31:0] i_instr,        // Encoding; narrow one in [15:0]
   input wire logic i_instr_wide,          // 1: 32-bit encoding
   input wire logic [31:0] i_pc,           // PC value seen by the instruction
   input wire logic [31:0] i_base_data,    // Value of o_base_sel register
   input wire logic [31:0] i_offset_data,  // Value of o_offset_sel register
   input wire logic i_mem_ready,           // Memory accepts request
   input wire logic i_mem_rvalid,          // Read data valid
   input wire logic [31:0] i_mem_rdata,    // Read data, low-aligned
   output logic o_instr_ready,             // Idle, can take instruction
   output logic [3:0] o_base_sel,          // Base register read select
   output logic [3:0] o_offset_sel,        // Offset register read select
   output logic o_mem_req,                 // Memory read request
   output logic [31:0] o_mem_addr,         // Memory byte address
   output logic o_mem_half,                // 1: halfword, 0: byte
   output logic o_mem_unpriv,              // Access with user permissions
   output logic o_dest_we,                 // Destination write pulse
   output logic [3:0] o_dest_sel,          // Destination register
   output logic [31:0] o_dest_data,        // Sign-extended load result
   output logic o_base_we,                 // Base writeback pulse
   output logic [31:0] o_base_wdata,       // Updated base value
   output logic o_preload,                 // Preload hint dispatch pulse
   output logic [31:0] o_preload_addr,     // Preload hint address
   output logic o_hint_nop,                // Memory hint retired as no-op
   output logic o_undefined,               // Undefined instruction pulse
   output logic o_unpredictable,           // Unpredictable encoding pulse
   output logic o_unclaimed,               // Not a signed load encoding
   output logic o_done                     // Instruction retired pulse
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // 13 and 15 are both barred in some register slots
   function automatic logic sld_sp_or_pc(input logic [3:0] r);
      return (r == `SLD_REG_SP) || (r == `SLD_REG_PC);
   endfunction

   // Widen a low-aligned byte or halfword by copying its top bit
   function automatic logic [31:0] sld_sext(input logic [31:0] raw,
                                            input logic half);
      logic [31:0] v;
      if (half) begin
         v = {{16{raw[15]}}, raw[15:0]};
      end else begin
         v = {{24{raw[7]}}, raw[7:0]};
      end
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   function automatic sld_dec_s sld_decode(input logic [31:0] ins,
                                           input logic wide);
      sld_dec_s d;
      logic [3:0] t;
      logic [3:0] n;
      logic p;
      logic u;
      logic w;
      d = '0;
      d.kind = SLD_K_OTHER;
      d.index = 1'b1;
      d.add = 1'b1;
      t = ins[`SLD_WIDE_DEST_HI:`SLD_WIDE_DEST_LO];
      n = ins[`SLD_WIDE_BASE_HI:`SLD_WIDE_BASE_LO];
      p = ins[`SLD_WIDE_PBIT];
      u = ins[`SLD_WIDE_UBIT8];
      w = ins[`SLD_WIDE_WBIT];
      if (!wide) begin
         if (ins[`SLD_NARROW_OP_HI:`SLD_NARROW_OP_LO] == `SLD_NARROW_OP) begin
            d.kind = SLD_K_LOAD;
            d.reg_form = 1'b1;
            d.shift = `SLD_SHIFT_NONE;
            d.offr = {1'b0, ins[`SLD_NARROW_OFF_HI:`SLD_NARROW_OFF_LO]};
            d.base = {1'b0, ins[`SLD_NARROW_BASE_HI:`SLD_NARROW_BASE_LO]};
            d.dest = {1'b0, ins[`SLD_NARROW_DEST_HI:`SLD_NARROW_DEST_LO]};
         end
      end else if (ins[`SLD_WIDE_OP_HI:`SLD_WIDE_OP_LO] == `SLD_WIDE_OP &&
                   !ins[`SLD_WIDE_ZERO] && ins[`SLD_WIDE_LOAD]) begin
         d.kind = SLD_K_LOAD;
         d.half = ins[`SLD_WIDE_HALF];
         d.dest = t;
         d.base = n;
         if (n == `SLD_REG_PC) begin
            // Literal form wins over every other layout
            d.pc_rel = 1'b1;
            d.add = ins[`SLD_WIDE_UBIT];
            d.imm = ins[`SLD_WIDE_WOFF_HI:0];
            d.unpred = (t == `SLD_REG_SP);
         end else if (ins[`SLD_WIDE_UBIT]) begin
            d.imm = ins[`SLD_WIDE_WOFF_HI:0];
            d.unpred = (t == `SLD_REG_SP);
         end else if (ins[`SLD_WIDE_NARROW_SEL]) begin
            d.imm = {4'h0, ins[`SLD_WIDE_NOFF_HI:0]};
            // Subtract, no writeback, dest 15: a hint slot, not a load
            if (t == `SLD_REG_PC && p && !u && !w) begin
               d.kind = d.half ? SLD_K_HINT : SLD_K_PRELOAD;
            end else if (p && u && !w) begin
               // User form keeps dest 15 as an unpredictable load
               d.unpriv = 1'b1;
               d.unpred = sld_sp_or_pc(t);
            end else if (!p && !w) begin
               d.kind = SLD_K_UNDEF;
            end else begin
               d.index = p;
               d.add = u;
               d.wback = w;
               d.unpred = (t == `SLD_REG_SP) || (w && n == t);
               if (t == `SLD_REG_PC && (!p || u || w)) begin
                  d.unpred = 1'b1;
               end
            end
         end else if (ins[`SLD_WIDE_REGZ_HI:`SLD_WIDE_REGZ_LO] == 6'h00) begin
            d.reg_form = 1'b1;
            d.shift = ins[`SLD_WIDE_SHIFT_HI:`SLD_WIDE_SHIFT_LO];
            d.offr = ins[`SLD_WIDE_OFF_HI:`SLD_WIDE_OFF_LO];
            d.unpred = (t == `SLD_REG_SP) || sld_sp_or_pc(d.offr);
         end else begin
            d.kind = SLD_K_OTHER;
         end
         // Dest 15 on a load turns into a hint, except for user form, post-index, writeback or narrow add
         if (d.kind == SLD_K_LOAD && t == `SLD_REG_PC && !d.unpriv &&
             !(d.wback || !d.index || (d.add && !d.pc_rel && !d.reg_form &&
               ins[`SLD_WIDE_NARROW_SEL] && !ins[`SLD_WIDE_UBIT]))) begin
            d.kind = d.half ? SLD_K_HINT : SLD_K_PRELOAD;
            d.unpred = 1'b0;
         end
      end
      return d;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Sequencing and datapath

   sld_state_e state_reg, state_next;
   sld_dec_s dec_reg, dec_next;
   logic [31:0] addr_reg, addr_next;
   logic [31:0] wb_addr_reg, wb_addr_next;
   logic dest_we_next, base_we_next, preload_next, hint_next;
   logic undef_next, unpred_next, unclaimed_next, done_next;
   logic [31:0] dest_data_next, preload_addr_next;
   logic [31:0] base_val;
   logic [31:0] offset_val;
   logic [31:0] offset_addr;
   logic [31:0] rd;

   always_comb begin
      // Literal loads take the word-aligned PC as their base
      base_val = dec_reg.pc_rel ? (i_pc & `SLD_PC_ALIGN_MASK) : i_base_data;
      offset_val = dec_reg.reg_form ? (i_offset_data << dec_reg.shift)
                                    : {20'h00000, dec_reg.imm};
      offset_addr = dec_reg.add ? (base_val + offset_val)
                                : (base_val - offset_val);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state and retire pulses

   always_comb begin
      rd = i_mem_rdata;
      state_next = state_reg;
      dec_next = dec_reg;
      addr_next = addr_reg;
      wb_addr_next = wb_addr_reg;
      dest_we_next = 1'b0;
      base_we_next = 1'b0;
      preload_next = 1'b0;
      hint_next = 1'b0;
      undef_next = 1'b0;
      unpred_next = 1'b0;
      unclaimed_next = 1'b0;
      done_next = 1'b0;
      dest_data_next = o_dest_data;
      preload_addr_next = o_preload_addr;
      case (state_reg)
         SLD_IDLE: begin
            // Decode is latched once so selects stay steady until the next take
            if (i_instr_valid) begin
               dec_next = sld_decode(i_instr, i_instr_wide);
               state_next = SLD_ADDR;
            end
         end
         SLD_ADDR: begin
            // Operand reads settle here; the address is registered for the request
            addr_next = dec_reg.index ? offset_addr : base_val;
            wb_addr_next = offset_addr;
            unpred_next = dec_reg.unpred;
            state_next = SLD_IDLE;
            done_next = 1'b1;
            case (dec_reg.kind)
               SLD_K_LOAD: begin
                  state_next = SLD_MEM;
                  done_next = 1'b0;
               end
               SLD_K_PRELOAD: begin
                  preload_next = 1'b1;
                  preload_addr_next = dec_reg.index ? offset_addr : base_val;
               end
               SLD_K_HINT: hint_next = 1'b1;
               SLD_K_UNDEF: undef_next = 1'b1;
               default: unclaimed_next = 1'b1;
            endcase
         end
         SLD_MEM: begin
            // Address and size stay registered while the request waits
            if (i_mem_ready) begin
               state_next = SLD_WAIT;
            end
         end
         SLD_WAIT: begin
            // Read data seen outside this state is ignored
            if (i_mem_rvalid) begin
               dest_we_next = 1'b1;
               dest_data_next = sld_sext(rd, dec_reg.half);
               base_we_next = dec_reg.wback;
               done_next = 1'b1;
               state_next = SLD_IDLE;
            end
         end
         default: state_next = SLD_IDLE;
      endcase
   end

   // Data outputs are registered so they hold between instructions
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_reg <= SLD_IDLE;
         dec_reg <= '0;
         addr_reg <= 32'h00000000;
         wb_addr_reg <= 32'h00000000;
         o_dest_we <= 1'b0;
         o_dest_data <= 32'h00000000;
         o_base_we <= 1'b0;
         o_preload <= 1'b0;
         o_preload_addr <= 32'h00000000;
         o_hint_nop <= 1'b0;
         o_undefined <= 1'b0;
         o_unpredictable <= 1'b0;
         o_unclaimed <= 1'b0;
         o_done <= 1'b0;
      end else begin
         state_reg <= state_next;
         dec_reg <= dec_next;
         addr_reg <= addr_next;
         wb_addr_reg <= wb_addr_next;
         o_dest_we <= dest_we_next;
         o_dest_data <= dest_data_next;
         o_base_we <= base_we_next;
         o_preload <= preload_next;
         o_preload_addr <= preload_addr_next;
         o_hint_nop <= hint_next;
         o_undefined <= undef_next;
         o_unpredictable <= unpred_next;
         o_unclaimed <= unclaimed_next;
         o_done <= done_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign o_instr_ready = (state_reg == SLD_IDLE);
   assign o_base_sel = dec_reg.base;
   assign o_offset_sel = dec_reg.offr;
   // Straight from state, so the request cannot drop before ready
   assign o_mem_req = (state_reg == SLD_MEM);
   assign o_mem_addr = addr_reg;
   assign o_mem_half = dec_reg.half;
   assign o_mem_unpriv = dec_reg.unpriv;
   assign o_dest_sel = dec_reg.dest;
   assign o_base_wdata = wb_addr_reg;

endmodule

`default_nettype wire

/* verif/sld_chk.sv */
// Port-level assertions for the signed load decoder
`timescale 1ns/1ps
`default_nettype none
module sld_chk (
   input wire logic i_clk, // Clock
   input wire logic i_rst_b, // Reset
   input wire logic i_instr_valid, // Offer
   input wire logic i_mem_ready, // Accept
   input wire logic i_mem_rvalid, // Data valid
   input wire logic o_instr_ready, // Idle
   input wire logic o_mem_req, // Request
   input wire logic [31:0] o_mem_addr, // Address
   input wire logic o_mem_half, // Size
   input wire logic o_dest_we, // Dest write
   input wire logic [31:0] o_dest_data, // Result
   input wire logic o_base_we, // Base write
   input wire logic o_preload, // Preload
   input wire logic o_hint_nop, // Hint
   input wire logic o_undefined, // Undefined
   input wire logic o_done // Retired
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   sequence s_take;
      o_instr_ready && i_instr_valid;
   endsequence
   sequence s_read;
      o_mem_req && i_mem_ready ##1 i_mem_rvalid;
   endsequence
   take_busy_a: assert property (s_take |=> !o_instr_ready && !o_done)
      else $error("busy not shown after take");
   decode_time_a: assert property (s_take |=> ##1 (o_mem_req || o_done))
      else $error("no request or retire two cycles after take");
   req_hold_a: assert property (o_mem_req && !i_mem_ready |=>
      o_mem_req && $stable(o_mem_addr))
      else $error("request dropped or address moved");
   read_done_a: assert property (s_read |=> o_dest_we && o_done)
      else $error("load not retired after read data");
   byte_sext_a: assert property (o_dest_we && !o_mem_half |->
      o_dest_data[31:8] == {24{o_dest_data[7]}})
      else $error("byte result not sign extended");
   half_sext_a: assert property (o_dest_we && o_mem_half |->
      o_dest_data[31:16] == {16{o_dest_data[15]}})
      else $error("halfword result not sign extended");
   wback_pair_a: assert property (o_base_we |-> o_dest_we && o_done)
      else $error("base write without load retire");
   preload_path_a: assert property (o_preload |->
      o_done && !o_dest_we && !o_base_we && !o_undefined)
      else $error("preload wrote a register or faulted");
   hint_quiet_a: assert property (o_hint_nop |->
      o_done && !o_dest_we && !o_base_we && !o_mem_req)
      else $error("hint had a side effect");
   undef_quiet_a: assert property (o_undefined |-> o_done && !o_dest_we && !o_base_we)
      else $error("undefined encoding wrote a register");
endmodule
bind sld_signed_load sld_chk chk_u (.i_clk, .i_rst_b, .i_instr_valid, .i_mem_ready,
   .i_mem_rvalid, .o_instr_ready, .o_mem_req, .o_mem_addr, .o_mem_half, .o_dest_we,
   .o_dest_data, .o_base_we, .o_preload, .o_hint_nop, .o_undefined, .o_done);
`default_nettype wire

/* verif/sld_mem_model.sv */
// Read-only memory model answering one read at a time
`timescale 1ns/1ps
`default_nettype none
module sld_mem_model (
   input wire logic i_clk, // Clock
   input wire logic i_req, // Read request
   input wire logic [1:0] i_dly, // Cycles before accept
   input wire logic [31:0] i_data, // Word to return
   output logic o_ready, // Accepts request
   output logic o_rvalid, // Data valid
   output logic [31:0] o_rdata // Read data
);
   logic [1:0] cnt;
   logic [1:0] ph;
   initial begin
      o_ready = 1'b0;
      o_rvalid = 1'b0;
      o_rdata = 32'h0;
      cnt = 2'h0;
      ph = 2'h0;
   end
   // Upper bytes carry junk so size masking is exercised
   always @(negedge i_clk) begin
      case (ph)
         2'h0: if (i_req === 1'b1) begin
            if (cnt == i_dly) begin
               o_ready <= 1'b1;
               ph <= 2'h1;
            end else cnt <= cnt + 2'h1;
         end
         2'h1: begin
            o_ready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= i_data;
            ph <= 2'h2;
         end
         // Released bus shows inverted data, never a stale copy
         default: begin
            o_rvalid <= 1'b0;
            o_rdata <= ~o_rdata;
            cnt <= 2'h0;
            ph <= 2'h0;
         end
      endcase
   end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking testbench for the signed load decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic i_clk, i_rst_b, i_instr_valid, i_instr_wide, i_mem_ready, i_mem_rvalid;
   logic [31:0] i_instr, i_pc, i_base_data, i_offset_data, i_mem_rdata, md;
   logic o_instr_ready, o_mem_req, o_mem_half, o_mem_unpriv, o_dest_we, o_base_we, o_preload;
   logic o_hint_nop, o_undefined, o_unpredictable, o_unclaimed, o_done;
   logic [3:0] o_base_sel, o_offset_sel, o_dest_sel;
   logic [31:0] o_mem_addr, o_dest_data, o_base_wdata, o_preload_addr, c_addr, c_data, c_wd;
   logic [1:0] dly, c_hm;
   logic [6:0] f;
   int n_mismatch = 0;
   int checks = 0;
   sld_signed_load dut_u (.i_clk, .i_rst_b, .i_instr_valid, .i_instr, .i_instr_wide, .i_pc,
      .i_base_data, .i_offset_data, .i_mem_ready, .i_mem_rvalid, .i_mem_rdata, .o_instr_ready,
      .o_base_sel, .o_offset_sel, .o_mem_req, .o_mem_addr, .o_mem_half, .o_mem_unpriv,
      .o_dest_we, .o_dest_sel, .o_dest_data, .o_base_we, .o_base_wdata, .o_preload,
      .o_preload_addr, .o_hint_nop, .o_undefined, .o_unpredictable, .o_unclaimed, .o_done);
   sld_mem_model mem_u (.i_clk(i_clk), .i_req(o_mem_req), .i_dly(dly), .i_data(md),
      .o_ready(i_mem_ready), .o_rvalid(i_mem_rvalid), .o_rdata(i_mem_rdata));
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
      end
   endtask
   task automatic env(input logic [31:0] pc, b, o, d);
      i_pc = pc;
      i_base_data = b;
      i_offset_data = o;
      md = d;
   endtask
   // Flags: dest_we base_we preload hint undef unpred unclaimed
   task automatic run(input logic [31:0] ins, input logic w, input logic [6:0] ef,
         input logic [31:0] ea);
      int n;
      f = 7'h0;
      c_addr = 32'h0;
      i_instr = ins;
      i_instr_wide = w;
      i_instr_valid = 1'b1;
      @(posedge i_clk);
      @(negedge i_clk);
      i_instr_valid = 1'b0;
      for (n = 0; n < 40; n++) begin
         f = f | {o_dest_we, o_base_we, o_preload, o_hint_nop, o_undefined, o_unpredictable,
            o_unclaimed};
         if (o_mem_req === 1'b1) begin
            c_addr = o_mem_addr;
            c_hm = {o_mem_half, o_mem_unpriv};
         end
         if (o_preload === 1'b1) c_addr = o_preload_addr;
         if (o_dest_we === 1'b1) c_data = o_dest_data;
         if (o_base_we === 1'b1) c_wd = o_base_wdata;
         if (o_done === 1'b1) break;
         @(negedge i_clk);
      end
      chk({31'h0, o_done}, 32'h1);
      chk({25'h0, f}, {25'h0, ef});
      chk(c_addr, ea);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_literal;
      env(32'h0000_1003, 32'h0, 32'h0, 32'hA5A5_5A80);
      run(32'hF99F_2123, 1'b1, 7'h40, 32'h0000_1123);
      chk(c_data, 32'hFFFF_FF80);
      run(32'hF91F_3000, 1'b1, 7'h40, 32'h0000_1000);
      run(32'hF91F_3010, 1'b1, 7'h40, 32'h0000_0FF0);
      run(32'hF99F_D004, 1'b1, 7'h42, 32'h0000_1004);
      run(32'hF99F_F010, 1'b1, 7'h10, 32'h0000_1010);
   endtask
   task automatic t_register;
      int s;
      for (s = 0; s < 4; s++) begin
         env(32'h0, 32'h0000_0100, 32'h0000_0011, 32'h1234_56FF);
         dly = s[1:0];
         run(32'hF914_5006 | (s << 4), 1'b1, 7'h40, 32'h100 + (32'h11 << s));
         chk(c_data, 32'hFFFF_FFFF);
      end
      dly = 2'h0;
      run(32'hF914_500D, 1'b1, 7'h42, 32'h0000_0111);
      run(32'hF914_F006, 1'b1, 7'h10, 32'h0000_0111);
      run(32'hF91F_5006, 1'b1, 7'h40, 32'hFFFF_FFFA);
      run(32'h0000_5653, 1'b0, 7'h40, 32'h0000_0111);
      chk({20'h0, o_offset_sel, o_base_sel, o_dest_sel}, 32'h0000_0123);
   endtask
   task automatic t_user;
      env(32'h0000_2000, 32'h0000_0400, 32'h0, 32'h0000_0001);
      run(32'hF914_4E7F, 1'b1, 7'h40, 32'h0000_047F);
      chk({30'h0, c_hm}, 32'h1);
      chk(c_data, 32'h1);
      run(32'hF914_DE00, 1'b1, 7'h42, 32'h0000_0400);
      run(32'hF91F_4E7F, 1'b1, 7'h40, 32'h0000_1181);
      run(32'hF914_4810, 1'b1, 7'h04, 32'h0);
      run(32'hF914_4A10, 1'b1, 7'h04, 32'h0);
   endtask
   task automatic t_half;
      env(32'h0000_3002, 32'h0000_0200, 32'h0, 32'h0000_8001);
      run(32'hF934_1D10, 1'b1, 7'h60, 32'h0000_01F0);
      chk(c_wd, 32'h0000_01F0);
      chk(c_data, 32'hFFFF_8001);
      chk({30'h0, c_hm}, 32'h2);
      run(32'hF934_1B10, 1'b1, 7'h60, 32'h0000_0200);
      chk(c_wd, 32'h0000_0210);
      run(32'hF934_4B10, 1'b1, 7'h62, 32'h0000_0200);
      run(32'hF934_FB10, 1'b1, 7'h62, 32'h0000_0200);
      run(32'hF934_FC10, 1'b1, 7'h08, 32'h0);
      run(32'hF9B4_F010, 1'b1, 7'h08, 32'h0);
      run(32'hF9BF_1002, 1'b1, 7'h40, 32'h0000_3002);
   endtask
   task automatic t_misc;
      env(32'h0, 32'h0000_1000, 32'h0, 32'h0000_0080);
      run(32'hF994_2FFF, 1'b1, 7'h40, 32'h0000_1FFF);
      run(32'hF914_2FFF, 1'b1, 7'h60, 32'h0000_10FF);
      run(32'h0000_0000, 1'b0, 7'h01, 32'h0);
      run(32'hF800_0000, 1'b1, 7'h01, 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      i_rst_b = 1'b0;
      i_instr_valid = 1'b0;
      i_instr = 32'h0;
      i_instr_wide = 1'b0;
      dly = 2'h0;
      env(32'h0, 32'h0, 32'h0, 32'h0);
      repeat (12) @(posedge i_clk);
      @(negedge i_clk);
      i_rst_b = 1'b1;
      t_literal;
      t_register;
      t_user;
      t_half;
      t_misc;
      report_and_stop;
   end
   // Whole run needs well under 1000 cycles
   initial begin
      #50000;
      n_mismatch++;
      report_and_stop;
   end
endmodule
`default_nettype wire
